// File: common/link_regs_pkg.sv
package link_regs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_CAP_ADDR = 8'hCC;
  localparam logic [7:0] LINK_CTRL_ADDR = 8'hD0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Link capabilities fields
  // ----------------------------------------------------------------
  localparam int CAP_SPEED_LSB = 0;
  localparam int CAP_WIDTH_LSB = 4;
  localparam int CAP_ASPM_LSB = 10;
  localparam int CAP_L0S_LSB = 12;
  localparam int CAP_L1_LSB = 15;
  localparam int CAP_DLAR_BIT = 20;
  localparam int CAP_BWN_BIT = 21;
  localparam int CAP_PORT_LSB = 24;
  localparam logic [3:0] CAP_SPEED_RST = 4'h2;
  localparam logic [5:0] CAP_WIDTH_VAL = 6'h01;
  localparam logic [1:0] CAP_ASPM_RST = 2'h0;
  localparam logic [2:0] CAP_L0S_RST = 3'h3;
  localparam logic [2:0] CAP_L1_RST = 3'h0;
  localparam logic [1:0] UPSTREAM_PORT_ID = 2'h0;

  // ----------------------------------------------------------------
  // Link control fields
  // ----------------------------------------------------------------
  localparam int CTL_ASPM_LSB = 0;
  localparam int CTL_RCB_BIT = 3;
  localparam int CTL_LDIS_BIT = 4;
  localparam int CTL_RETRAIN_BIT = 5;
  localparam int CTL_CCLK_BIT = 6;
  localparam int CTL_XSYNC_BIT = 7;
  localparam int CTL_HAWD_BIT = 9;
  localparam int CTL_BWMIE_BIT = 10;
  localparam int CTL_BWAIE_BIT = 11;

  // ----------------------------------------------------------------
  // Ordered-set counts on leaving low-power states
  // ----------------------------------------------------------------
  localparam logic [12:0] FTS_EXT_COUNT = 13'h1000;
  localparam logic [12:0] FTS_NORM_COUNT = 13'h0080;
  localparam logic [10:0] TS1_EXT_COUNT = 11'h400;
  localparam logic [10:0] TS1_NORM_COUNT = 11'h010;

  // Override of capability defaults from the SMBus or EEPROM loader
  typedef struct packed {
    logic [3:0] speed;
    logic [1:0] aspm;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
    logic [7:0] port_num;
  } cap_load_s;

  // Control levels handed to the link training logic
  typedef struct packed {
    logic l0s_en;
    logic l1_en;
    logic rx_l0s_ok;
    logic link_disable;
    logic common_clk;
    logic ext_synch;
    logic hw_width_dis;
    logic bw_mgmt_ie;
    logic bw_auto_ie;
  } link_ctrl_s;

endpackage : link_regs_pkg

// File: dv/link_train_model.sv
module link_train_model
  import link_regs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire link_ctrl_s link_ctrl,
  input wire logic retrain_pulse,
  output logic [7:0] retrain_cnt_r,
  output logic link_up_r
);
  timeunit 1ns;
  timeprecision 100ps;

  // Training side: counts retrain requests, drops the link while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retrain_cnt_r <= 8'h00;
      link_up_r <= 1'b0;
    end else begin
      if (retrain_pulse) retrain_cnt_r <= retrain_cnt_r + 8'h01;
      link_up_r <= !link_ctrl.link_disable;
    end
  end
endmodule : link_train_model

// File: dv/tb_link_cap_ctrl_regs.sv
module tb_link_cap_ctrl_regs
  import link_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Two ports: index 0 upstream, index 1 downstream
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr [2], araddr [2];
  logic [31:0] wdata [2], rdata [2];
  logic [3:0] wstrb [2];
  logic [1:0] bresp [2], rresp [2];
  logic awvalid [2], awready [2], wvalid [2], wready [2], bvalid [2], bready [2];
  logic arvalid [2], arready [2], rvalid [2], rready [2], rtp [2], lup [2];
  logic cap_load_valid = 1'b0;
  cap_load_s cap_load = '0;
  link_ctrl_s lc [2];
  logic [12:0] fts [2];
  logic [10:0] ts1 [2];
  logic [7:0] rtc [2];
  int err_total = 0;
  int total_checks = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #25 aclk = ~aclk;

  for (genvar g = 0; g < 2; g++) begin : port_g
    link_cap_ctrl_regs #(.port_id(2'(g))) link_cap_ctrl_regs_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr[g]), .s_axi_awvalid(awvalid[g]), .s_axi_awready(awready[g]),
      .s_axi_wdata(wdata[g]), .s_axi_wstrb(wstrb[g]), .s_axi_wvalid(wvalid[g]),
      .s_axi_wready(wready[g]), .s_axi_bresp(bresp[g]), .s_axi_bvalid(bvalid[g]),
      .s_axi_bready(bready[g]), .s_axi_araddr(araddr[g]), .s_axi_arvalid(arvalid[g]),
      .s_axi_arready(arready[g]), .s_axi_rdata(rdata[g]), .s_axi_rresp(rresp[g]),
      .s_axi_rvalid(rvalid[g]), .s_axi_rready(rready[g]),
      .cap_load_valid(cap_load_valid), .cap_load(cap_load), .link_ctrl(lc[g]),
      .retrain_pulse(rtp[g]), .fts_count(fts[g]), .ts1_count(ts1[g])
    );
    link_train_model link_train_model_i (
      .aclk(aclk), .aresetn(aresetn), .link_ctrl(lc[g]), .retrain_pulse(rtp[g]),
      .retrain_cnt_r(rtc[g]), .link_up_r(lup[g])
    );
  end

  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Address and data offered together; each dropped once its own ready is seen
  task automatic wr(input int p, input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s, output logic [1:0] resp);
    @(posedge aclk);
    awaddr[p] <= a;
    wdata[p] <= v;
    wstrb[p] <= s;
    awvalid[p] <= 1'b1;
    wvalid[p] <= 1'b1;
    bready[p] <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready[p] === 1'b1) awvalid[p] <= 1'b0;
      if (wready[p] === 1'b1) wvalid[p] <= 1'b0;
    end while (bvalid[p] !== 1'b1);
    resp = bresp[p];
    bready[p] <= 1'b0;
  endtask : wr

  task automatic rd(input int p, input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr[p] <= a;
    arvalid[p] <= 1'b1;
    rready[p] <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready[p] === 1'b1) arvalid[p] <= 1'b0;
    end while (rvalid[p] !== 1'b1);
    v = rdata[p];
    resp = rresp[p];
    rready[p] <= 1'b0;
  endtask : rd

  // Expected capability word; only downstream ports advertise bandwidth notify
  function automatic logic [31:0] exp_cap(input int p, input logic [3:0] sp,
      input logic [1:0] asp, input logic [2:0] l0, input logic [2:0] l1, input logic [7:0] pn);
    return {pn, 2'h0, (p != 0), 1'b0, 2'h0, l1, l0, asp, CAP_WIDTH_VAL, sp};
  endfunction : exp_cap

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int p = 0; p < 2; p++) begin
      {awaddr[p], araddr[p], wdata[p], wstrb[p]} <= '0;
      {awvalid[p], wvalid[p], bready[p], arvalid[p], rready[p]} <= '0;
    end
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      rd(p, LINK_CAP_ADDR, d, r);
      chk(d, exp_cap(p, 4'h2, 2'h0, 3'h3, 3'h0, 8'(p)), "cap reset");
      chk(32'(r), 32'(RESP_OKAY), "cap resp");
      rd(p, LINK_CTRL_ADDR, d, r);
      chk(d, 32'h0000_0000, "ctrl reset");
      chk(32'(lc[p].rx_l0s_ok), 32'h0000_0001, "rx l0s");
      // All ones shows which bits each port kind accepts
      wr(p, LINK_CTRL_ADDR, 32'hFFFF_FFFF, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY), "ctrl wr resp");
      rd(p, LINK_CTRL_ADDR, d, r);
      chk(d, (p != 0) ? 32'h0000_0ED3 : 32'h0000_02C3, "ctrl ones");
      chk(32'(lc[p].link_disable), 32'(p != 0), "disable");
      chk(32'(lup[p]), 32'(p == 0), "link up");
      chk(32'(rtc[p]), 32'(p != 0), "retrain");
      chk(32'(lc[p].common_clk), 32'h0000_0001, "cclk");
      chk(32'(lc[p].ext_synch), 32'h0000_0001, "xsync");
      chk(32'(lc[p].hw_width_dis), 32'h0000_0001, "hawd");
      chk(32'({lc[p].bw_mgmt_ie, lc[p].bw_auto_ie}), (p != 0) ? 32'h0000_0003 : 32'h0000_0000,
          "bw ie");
      chk(32'(fts[p]), 32'h0000_1000, "fts ext");
      chk(32'(ts1[p]), 32'h0000_0400, "ts1 ext");
      // Lane 0 only: upper byte must survive
      for (int i = 0; i < 4; i++) begin
        wr(p, LINK_CTRL_ADDR, 32'(3 - i), 4'h1, r);
        chk(32'({lc[p].l1_en, lc[p].l0s_en}), 32'(3 - i), "aspm");
        chk(32'(lc[p].rx_l0s_ok), 32'h0000_0001, "rx l0s");
      end
      repeat (2) @(posedge aclk);
      chk(32'(fts[p]), 32'(FTS_NORM_COUNT), "fts norm");
      chk(32'(ts1[p]), 32'(TS1_NORM_COUNT), "ts1 norm");
      rd(p, LINK_CTRL_ADDR, d, r);
      chk(d, (p != 0) ? 32'h0000_0E00 : 32'h0000_0200, "ctrl lane");
      wr(p, LINK_CAP_ADDR, 32'h0000_0000, 4'hF, r);
      chk(32'(r), 32'(RESP_OKAY), "cap wr resp");
      // Software writes must leave the capability word alone
      rd(p, LINK_CAP_ADDR, d, r);
      chk(d, exp_cap(p, 4'h2, 2'h0, 3'h3, 3'h0, 8'(p)), "cap after wr");
      wr(p, 8'h40, 32'hFFFF_FFFF, 4'hF, r);
      chk(32'(r), 32'(RESP_SLVERR), "unmapped wr");
      rd(p, 8'h40, d, r);
      chk(d, 32'h0000_0000, "unmapped rd");
      chk(32'(r), 32'(RESP_SLVERR), "unmapped rd resp");
    end
    // Override of the capability defaults reaches both ports
    @(posedge aclk);
    cap_load <= '{speed: 4'h1, aspm: 2'h3, l0s_lat: 3'h5, l1_lat: 3'h6, port_num: 8'h5A};
    cap_load_valid <= 1'b1;
    @(posedge aclk);
    cap_load_valid <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      rd(p, LINK_CAP_ADDR, d, r);
      chk(d, exp_cap(p, 4'h1, 2'h3, 3'h5, 3'h6, 8'h5A), "cap load");
    end
    // A reset in mid-run brings back the defaults over a loaded value
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      rd(p, LINK_CAP_ADDR, d, r);
      chk(d, exp_cap(p, 4'h2, 2'h0, 3'h3, 3'h0, 8'(p)), "cap re-reset");
      rd(p, LINK_CTRL_ADDR, d, r);
      chk(d, 32'h0000_0000, "ctrl re-reset");
    end
    print_verdict();
  end

  // Whole run needs about 120 cycles; this allows far more
  initial begin
    #2000000;
    err_total++;
    print_verdict();
  end
endmodule : tb_link_cap_ctrl_regs

// File: verilog/link_cap_ctrl_regs.sv
// Behaviour
// - Max link speed bits 3:0, reset 0010b
// - Max width bits 9:4 read-only, x1
// - ASPM support bits 11:10 read-only, reset 00b
// - L0s exit latency bits 14:12, reset 011b
// - L1 exit latency bits 17:15, reset 000b
// - DL active reporting bit 20 zero
// - Bandwidth notify bit 21: upstream 0, downstream 1
// - Port number bits 31:24, reset equals port index
// - SMBus/EEPROM load replaces capability defaults
// - ASPM control bits 1:0 decode, reset 00b
// - Receiver may always enter L0s
// - RCB bit 3 always reads zero
// - Link disable: upstream zero, downstream disables
// - Retrain on writing bit 5, downstream only, reads zero
// - Common clock bit 6 read-write, reset zero
// - Extended synch: 4096 FTS, 1024 TS1
// - Autonomous width disable bit 9 read-write
// - Bits 10,11 writable downstream, upstream read-only
module link_cap_ctrl_regs
  import link_regs_pkg::*;
#(
  parameter logic [1:0] port_id = 2'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cap_load_valid,
  input wire cap_load_s cap_load,
  output link_ctrl_s link_ctrl,
  output logic retrain_pulse,
  output logic [12:0] fts_count,
  output logic [10:0] ts1_count
);

  // ----------------------------------------------------------------
  // Port role
  // ----------------------------------------------------------------
  // Upstream port cannot disable or retrain its own link
  localparam logic is_up = (port_id == UPSTREAM_PORT_ID);
  localparam logic [7:0] port_num_rst = {6'h00, port_id};

  // ----------------------------------------------------------------
  // Write channel holding
  // ----------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic awready_r;
  logic wready_r;

  wire aw_fire = s_axi_awvalid & awready_r;
  wire w_fire = s_axi_wvalid & wready_r;
  wire aw_have = aw_hold_r | aw_fire;
  wire w_have = w_hold_r | w_fire;
  wire do_write = aw_have & w_have & ~bvalid_r;
  wire [7:0] wr_addr = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_hold_r ? wdata_r : s_axi_wdata;
  wire [3:0] wr_strb = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire b_done = bvalid_r & s_axi_bready;
  wire aw_hold_nxt = aw_have & ~do_write;
  wire w_hold_nxt = w_have & ~do_write;
  wire bvalid_nxt = (bvalid_r & ~b_done) | do_write;

  // Address decode for writes
  wire wr_cap = (wr_addr == LINK_CAP_ADDR);
  wire wr_ctl = (wr_addr == LINK_CTRL_ADDR);
  wire wr_ctl_lo = do_write & wr_ctl & wr_strb[0];
  wire wr_ctl_hi = do_write & wr_ctl & wr_strb[1];
  wire [1:0] wr_resp = (wr_cap | wr_ctl) ? RESP_OKAY : RESP_SLVERR;

  // One write in flight; readiness drops until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      bvalid_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      bvalid_r <= bvalid_nxt;
      awready_r <= ~aw_hold_nxt & ~bvalid_nxt;
      wready_r <= ~w_hold_nxt & ~bvalid_nxt;
    end
  end

  // Payload capture and response code
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        bresp_r <= wr_resp;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capability fields
  // ----------------------------------------------------------------
  logic [3:0] cap_speed_r;
  logic [1:0] cap_aspm_r;
  logic [2:0] cap_l0s_r;
  logic [2:0] cap_l1_r;
  logic [7:0] cap_port_r;

  // Loader overrides the defaults; software writes never reach these
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_speed_r <= CAP_SPEED_RST;
      cap_aspm_r <= CAP_ASPM_RST;
      cap_l0s_r <= CAP_L0S_RST;
      cap_l1_r <= CAP_L1_RST;
      cap_port_r <= port_num_rst;
    end else if (cap_load_valid) begin
      cap_speed_r <= cap_load.speed;
      cap_aspm_r <= cap_load.aspm;
      cap_l0s_r <= cap_load.l0s_lat;
      cap_l1_r <= cap_load.l1_lat;
      cap_port_r <= cap_load.port_num;
    end
  end

  // Width fixed at x1; reporting bit 20 held low; bit 21 by port role
  wire [31:0] cap_word = {cap_port_r, 2'h0, ~is_up, 1'b0, 2'h0,
                          cap_l1_r, cap_l0s_r, cap_aspm_r,
                          CAP_WIDTH_VAL, cap_speed_r};

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  logic [1:0] ctl_aspm_r;
  logic ctl_ldis_r;
  logic ctl_cclk_r;
  logic ctl_xsync_r;
  logic ctl_hawd_r;
  logic ctl_bwmie_r;
  logic ctl_bwaie_r;
  logic retrain_r;

  // Downstream-only bits simply load as zero on the upstream port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_aspm_r <= 2'h0;
      ctl_ldis_r <= 1'b0;
      ctl_cclk_r <= 1'b0;
      ctl_xsync_r <= 1'b0;
      ctl_hawd_r <= 1'b0;
      ctl_bwmie_r <= 1'b0;
      ctl_bwaie_r <= 1'b0;
      retrain_r <= 1'b0;
    end else begin
      retrain_r <= wr_ctl_lo & ~is_up & wr_data[CTL_RETRAIN_BIT];
      if (wr_ctl_lo) begin
        ctl_aspm_r <= wr_data[CTL_ASPM_LSB +: 2];
        ctl_ldis_r <= wr_data[CTL_LDIS_BIT] & ~is_up;
        ctl_cclk_r <= wr_data[CTL_CCLK_BIT];
        ctl_xsync_r <= wr_data[CTL_XSYNC_BIT];
      end
      if (wr_ctl_hi) begin
        ctl_hawd_r <= wr_data[CTL_HAWD_BIT];
        ctl_bwmie_r <= wr_data[CTL_BWMIE_BIT] & ~is_up;
        ctl_bwaie_r <= wr_data[CTL_BWAIE_BIT] & ~is_up;
      end
    end
  end

  // Bits 2, 3, 5, 8 and 15:12 read back as zero; upper half unused here
  wire [31:0] ctl_word = {16'h0000, 4'h0, ctl_bwaie_r, ctl_bwmie_r,
                          ctl_hawd_r, 1'b0, ctl_xsync_r, ctl_cclk_r,
                          1'b0, ctl_ldis_r, 1'b0, 1'b0, ctl_aspm_r};

  // ----------------------------------------------------------------
  // Link-facing outputs
  // ----------------------------------------------------------------
  // Counts are registered so the link logic sees stable values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fts_count <= FTS_NORM_COUNT;
      ts1_count <= TS1_NORM_COUNT;
    end else begin
      fts_count <= ctl_xsync_r ? FTS_EXT_COUNT : FTS_NORM_COUNT;
      ts1_count <= ctl_xsync_r ? TS1_EXT_COUNT : TS1_NORM_COUNT;
    end
  end

  // Levels come straight from the control flops, except rx_l0s_ok, which is tied high
  assign link_ctrl.l0s_en = ctl_aspm_r[0];
  assign link_ctrl.l1_en = ctl_aspm_r[1];
  assign link_ctrl.rx_l0s_ok = 1'b1;
  assign link_ctrl.link_disable = ctl_ldis_r;
  assign link_ctrl.common_clk = ctl_cclk_r;
  assign link_ctrl.ext_synch = ctl_xsync_r;
  assign link_ctrl.hw_width_dis = ctl_hawd_r;
  assign link_ctrl.bw_mgmt_ie = ctl_bwmie_r;
  assign link_ctrl.bw_auto_ie = ctl_bwaie_r;
  assign retrain_pulse = retrain_r;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] raddr_r;

  wire ar_fire = s_axi_arvalid & arready_r;
  wire r_done = rvalid_r & s_axi_rready;
  wire rd_cap = (s_axi_araddr == LINK_CAP_ADDR);
  wire rd_ctl = (s_axi_araddr == LINK_CTRL_ADDR);
  wire [31:0] rd_word = rd_cap ? cap_word : (rd_ctl ? ctl_word : 32'h0000_0000);
  wire [1:0] rd_resp = (rd_cap | rd_ctl) ? RESP_OKAY : RESP_SLVERR;

  // One read in flight; data is sampled on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
      raddr_r <= 8'h00;
    end else if (ar_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_resp;
      raddr_r <= s_axi_araddr;
    end else if (r_done | ~rvalid_r) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wire rd_cap_out = rvalid_r & (raddr_r == LINK_CAP_ADDR);
  wire rd_ctl_out = rvalid_r & (raddr_r == LINK_CTRL_ADDR);

  property p_cap_fixed;
    @(posedge aclk) disable iff (!aresetn)
      rd_cap_out |-> (rdata_r[9:4] == CAP_WIDTH_VAL) && (rdata_r[20] == 1'b0)
        && (rdata_r[21] == ~is_up) && (rdata_r[23:22] == 2'h0)
        && (rdata_r[19:18] == 2'h0);
  endproperty
  a_cap_fixed: assert property (p_cap_fixed) else $error("capability fixed bits wrong");

  property p_ctl_zero_bits;
    @(posedge aclk) disable iff (!aresetn)
      rd_ctl_out |-> (rdata_r[3] == 1'b0) && (rdata_r[5] == 1'b0)
        && (rdata_r[2] == 1'b0) && (rdata_r[8] == 1'b0) && (rdata_r[31:12] == 20'h00000);
  endproperty
  a_ctl_zero_bits: assert property (p_ctl_zero_bits) else $error("control zero bits set");

  property p_reset_values;
    @(posedge aclk) disable iff (!aresetn)
      !$past(aresetn) |-> (cap_speed_r == CAP_SPEED_RST) && (cap_l0s_r == CAP_L0S_RST)
        && (cap_port_r == port_num_rst) && (ctl_aspm_r == 2'h0) && !ctl_cclk_r;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_load;
    @(posedge aclk) disable iff (!aresetn)
      cap_load_valid |=> (cap_port_r == $past(cap_load.port_num))
        && (cap_speed_r == $past(cap_load.speed)) && (cap_l1_r == $past(cap_load.l1_lat));
  endproperty
  a_load: assert property (p_load) else $error("capability load not applied");

  property p_up_locked;
    @(posedge aclk) disable iff (!aresetn)
      is_up |-> !link_ctrl.link_disable && !retrain_pulse && !ctl_bwmie_r && !ctl_bwaie_r;
  endproperty
  a_up_locked: assert property (p_up_locked) else $error("upstream port bit changed");

  property p_retrain;
    @(posedge aclk) disable iff (!aresetn)
      (wr_ctl_lo && wr_data[CTL_RETRAIN_BIT] && !is_up) |=> retrain_pulse ##1 !retrain_pulse;
  endproperty
  a_retrain: assert property (p_retrain) else $error("retrain pulse wrong");

  property p_ext_synch;
    @(posedge aclk) disable iff (!aresetn)
      ctl_xsync_r[*2] |-> (fts_count == FTS_EXT_COUNT) && (ts1_count == TS1_EXT_COUNT);
  endproperty
  a_ext_synch: assert property (p_ext_synch) else $error("extended synch counts wrong");

  property p_aspm_decode;
    @(posedge aclk) disable iff (!aresetn)
      wr_ctl_lo |=> (link_ctrl.l1_en == $past(wr_data[1]))
        && (link_ctrl.l0s_en == $past(wr_data[0])) && link_ctrl.rx_l0s_ok;
  endproperty
  a_aspm_decode: assert property (p_aspm_decode) else $error("ASPM decode wrong");

  property p_bresp;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && awready_r && s_axi_wvalid && wready_r) |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");

endmodule : link_cap_ctrl_regs
